// ==== src/flash_seq_defs.svh ====
// Overview of operation
// RULE_01: protected region entry: AA@555, 55@2AA, 88@555 (byte: AAA/555/AAA).
// RULE_02: protected region exit: AA@555, 55@2AA, 90@555, then 00 anywhere.
// RULE_03: program: AA@555, 55@2AA, A0@555, then data at target address.
// RULE_04: device latches address on later falling strobe edge.
// RULE_05: device latches data on earlier rising strobe edge.
// RULE_06: bypass entry: AA@555, 55@2AA, 20@555.
// RULE_07: in bypass, program is A0 anywhere then data at target address.
// RULE_08: bypass exit: 90 to bank address, then 00 anywhere.
// RULE_09: chip erase: six writes ending with 10@555.
// RULE_10: sector erase: same five writes, then 30 at sector address.
// RULE_11: erase suspend: B0 to bank address, only during sector erase.
// RULE_12: erase resume: 30 to bank address, only while suspended.
// RULE_13: while suspended, device allows reads, programs and autoselect elsewhere.
// RULE_14: query: 98@55 (byte: AA), from array read or autoselect.
// RULE_15: all command cycles are writes except plain read and autoselect 4th.
// RULE_16: upper data byte ignored in command cycles.
// RULE_17: upper ten address bits ignored except sector or program addresses.
// RULE_18: reset command leaves autoselect or recovers after timeout flag.
// RULE_19: autoselect reads carry bank address; id read over cycles 4-6 (code reads in cycle 4 only).
// RULE_20: protected region readout: 80 factory, 40 customer, 00 neither.
// RULE_21: sector protection readout: 00 unprotected, 01 protected.
// RULE_22: device reports progress on status bits and ready_busy_n pin.
// RULE_23: during sector erase only suspend is accepted.
// RULE_24: suspended state reached within 20 us of suspend.
// RULE_25: mismatching cycle abandons partial sequence back to array read.
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH
`define ADR_UNLOCK1_W   22'h00_0555
`define ADR_UNLOCK2_W   22'h00_02AA
`define ADR_UNLOCK1_B   22'h00_0AAA
`define ADR_UNLOCK2_B   22'h00_0555
`define ADR_QUERY_W     22'h00_0055
`define ADR_QUERY_B     22'h00_00AA
`define DAT_UNLOCK1     8'hAA
`define DAT_UNLOCK2     8'h55
`define DAT_REGION_IN   8'h88
`define DAT_AUTOSEL     8'h90
`define DAT_ZERO        8'h00
`define DAT_PROGRAM     8'hA0
`define DAT_BYPASS      8'h20
`define DAT_ERASE       8'h80
`define DAT_CHIP_ERASE  8'h10
`define DAT_SECT_ERASE  8'h30
`define DAT_SUSPEND     8'hB0
`define DAT_RESUME      8'h30
`define DAT_QUERY       8'h98
`define DAT_RESET       8'hF0
`define ADR_BANK_LSB    19
`define ADR_SECTOR_LSB  12
// register offsets
`define REG_CTRL        4'h0
`define REG_ADDR        4'h4
`define REG_DATA        4'h8
`define REG_STATUS      4'hC
`define CTRL_GO_BIT     0
`define CTRL_BYTE_BIT   1
`define CTRL_OP_LSB     4
// timing: 40 ns clock
`define CLK_PERIOD_NS   40
`define T_STROBE_NS     70
`define T_SETUP_NS      40
`define T_HOLD_NS       40
`define CYC_STROBE      ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_SETUP       ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_HOLD        ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== src/flash_seq_pkg.sv ====
package flash_seq_pkg;
	typedef enum logic [3:0] {
		OP_READ        = 4'h0,
		OP_RESET       = 4'h1,
		OP_PROGRAM     = 4'h2,
		OP_REGION_IN   = 4'h3,
		OP_REGION_OUT  = 4'h4,
		OP_BYPASS_IN   = 4'h5,
		OP_BYPASS_PROG = 4'h6,
		OP_BYPASS_OUT  = 4'h7,
		OP_CHIP_ERASE  = 4'h8,
		OP_SECT_ERASE  = 4'h9,
		OP_SUSPEND     = 4'hA,
		OP_RESUME      = 4'hB,
		OP_QUERY       = 4'hC,
		OP_AUTOSELECT  = 4'hD
	} op_t;
	typedef enum logic [5:0] {
		ST_IDLE  = 6'b00_0001,
		ST_SETUP = 6'b00_0010,
		ST_PULSE = 6'b00_0100,
		ST_HOLD  = 6'b00_1000,
		ST_NEXT  = 6'b01_0000,
		ST_DONE  = 6'b10_0000
	} bus_st_t;
	typedef struct packed {
		logic        is_read;
		logic [21:0] addr;
		logic [15:0] data;
	} cyc_t;
endpackage : flash_seq_pkg

// ==== src/flash_bus_cycle.sv ====
`timescale 1ns/1ps
`include "flash_seq_defs.svh"
// one asynchronous write or read cycle on the flash pins
module flash_bus_cycle (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic        is_read,
	input  wire logic [21:0] addr,
	input  wire logic [15:0] wdata,
	output logic             done,
	output logic [15:0]      rdata,
	output logic [21:0]      fl_addr,
	output logic [15:0]      fl_dq_out,
	output logic             fl_dq_oe,
	input  wire logic [15:0] fl_dq_in,
	output logic             fl_ce_n,
	output logic             fl_we_n,
	output logic             fl_oe_n
);
	import flash_seq_pkg::*;
	localparam logic [3:0] C_SETUP  = 4'(`CYC_SETUP);
	localparam logic [3:0] C_STROBE = 4'(`CYC_STROBE);
	localparam logic [3:0] C_HOLD   = 4'(`CYC_HOLD);
	bus_st_t    st_ff;
	logic [3:0] cnt_ff;
	logic       rd_ff;

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			st_ff     <= ST_IDLE;
			cnt_ff    <= 4'h0;
			rd_ff     <= 1'b0;
			fl_addr   <= 22'h00_0000;
			fl_dq_out <= 16'h0000;
			fl_dq_oe  <= 1'b0;
			fl_ce_n   <= 1'b1;
			fl_we_n   <= 1'b1;
			fl_oe_n   <= 1'b1;
			rdata     <= 16'h0000;
			done      <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (st_ff)
				ST_IDLE: if (start) begin
					// address stable before either strobe falls
					rd_ff     <= is_read;
					fl_addr   <= addr;
					fl_dq_out <= wdata;
					fl_dq_oe  <= !is_read;
					fl_ce_n   <= 1'b0;
					cnt_ff    <= C_SETUP;
					st_ff     <= ST_SETUP;
				end
				ST_SETUP: if (cnt_ff <= 4'h1) begin
					fl_we_n <= rd_ff; // RULE_04 RULE_15
					fl_oe_n <= !rd_ff;
					cnt_ff  <= C_STROBE;
					st_ff   <= ST_PULSE;
				end else begin
					cnt_ff <= cnt_ff - 4'h1;
				end
				ST_PULSE: if (cnt_ff <= 4'h1) begin
					// strobe rises first, data held past it
					fl_we_n <= 1'b1; // RULE_05
					fl_oe_n <= 1'b1;
					rdata   <= fl_dq_in;
					cnt_ff  <= C_HOLD;
					st_ff   <= ST_HOLD;
				end else begin
					cnt_ff <= cnt_ff - 4'h1;
				end
				ST_HOLD: if (cnt_ff <= 4'h1) begin
					fl_ce_n  <= 1'b1;
					fl_dq_oe <= 1'b0;
					done     <= 1'b1;
					st_ff    <= ST_IDLE;
				end else begin
					cnt_ff <= cnt_ff - 4'h1;
				end
				default: st_ff <= ST_IDLE;
			endcase
		end
	end
endmodule : flash_bus_cycle

// ==== src/flash_seq_host.sv ====
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "flash_seq_defs.svh"
// host controller issuing flash command sequences, ordered over AXI4-Lite
module flash_seq_host (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [21:0]      fl_addr,
	output logic [15:0]      fl_dq_out,
	output logic             fl_dq_oe,
	input  wire logic [15:0] fl_dq_in,
	output logic             fl_ce_n,
	output logic             fl_we_n,
	output logic             fl_oe_n,
	input  wire logic        ready_busy_n
);
	import flash_seq_pkg::*;

	// register state
	op_t         op_ff;
	logic        byte_ff;
	logic        busy_ff;
	logic [21:0] addr_ff;
	logic [15:0] data_ff;
	logic [15:0] rd_ff;
	logic        bypass_ff;
	logic        region_ff;
	logic        susp_ff;
	logic        serase_ff;
	logic        autosel_ff;
	logic        err_ff;
	// sequencer
	logic [2:0]  idx_ff;
	logic        cyc_start;
	logic        cyc_done;
	cyc_t        cur;
	logic [2:0]  n_cyc;
	logic [15:0] cyc_rdata;
	logic        legal;

	function automatic cyc_t wr(input logic [21:0] a, input logic [7:0] d);
		wr = '{is_read: 1'b0, addr: a, data: {8'h00, d}}; // RULE_16
	endfunction : wr

	// unlock addresses by bus width
	function automatic logic [21:0] ua(input logic second,
		input logic bmode);
		if (second)
			ua = bmode ? `ADR_UNLOCK2_B : `ADR_UNLOCK2_W;
		else
			ua = bmode ? `ADR_UNLOCK1_B : `ADR_UNLOCK1_W;
	endfunction : ua

	// bank address plus low unlock offset; upper bits only from bank
	function automatic logic [21:0] bank(input logic [21:0] a,
		input logic [21:0] lo);
		bank = {a[21:`ADR_BANK_LSB], lo[`ADR_BANK_LSB-1:0]}; // RULE_11
	endfunction : bank

	logic [21:0] u1;
	logic [21:0] u2;
	assign u1 = ua(1'b0, byte_ff);
	assign u2 = ua(1'b1, byte_ff);

	// judged on the order being written; op_ff still holds the last one
	op_t         new_op;
	assign new_op = op_t'(s_axi_wdata[`CTRL_OP_LSB +: 4]);

	// which orders are legal in the current device mode
	always_comb begin
		legal = 1'b1;
		unique case (new_op)
			OP_READ, OP_RESET: legal = 1'b1;
			OP_BYPASS_PROG, OP_BYPASS_OUT: legal = bypass_ff; // RULE_07 RULE_08
			OP_SUSPEND: legal = serase_ff && !susp_ff; // RULE_11
			OP_RESUME:  legal = susp_ff && !autosel_ff; // RULE_12
			OP_QUERY:   legal = !bypass_ff && (!susp_ff || autosel_ff); // RULE_14
			OP_CHIP_ERASE, OP_SECT_ERASE, OP_REGION_IN, OP_REGION_OUT,
			OP_BYPASS_IN: legal = !bypass_ff && !susp_ff;
			OP_PROGRAM, OP_AUTOSELECT: legal = !bypass_ff;
			// codes outside the order set are refused
			default: legal = 1'b0;
		endcase
		// sector erase busy: only suspend goes through
		if (serase_ff && !susp_ff && new_op != OP_SUSPEND)
			legal = 1'b0; // RULE_23
	end

	// cycle count and content per order
	always_comb begin
		n_cyc = 3'd1;
		cur   = wr(addr_ff, data_ff[7:0]);
		unique case (op_ff)
			OP_READ: begin
				cur = '{is_read: 1'b1, addr: addr_ff, data: 16'h0000};
			end
			OP_RESET: cur = wr(addr_ff, `DAT_RESET); // RULE_18
			OP_REGION_IN, OP_BYPASS_IN, OP_REGION_OUT, OP_PROGRAM,
			OP_AUTOSELECT: begin
				n_cyc = (op_ff == OP_REGION_IN || op_ff == OP_BYPASS_IN)
					? 3'd3 : 3'd4;
				unique case (idx_ff)
					3'd0: cur = wr(u1, `DAT_UNLOCK1);
					3'd1: cur = wr(u2, `DAT_UNLOCK2);
					3'd2: cur = wr(op_ff == OP_AUTOSELECT ? bank(addr_ff, u1) : u1,
						op_ff == OP_REGION_IN ? `DAT_REGION_IN : // RULE_01
						op_ff == OP_BYPASS_IN ? `DAT_BYPASS :    // RULE_06
						op_ff == OP_PROGRAM ? `DAT_PROGRAM :     // RULE_03
						`DAT_AUTOSEL);
					default: cur = (op_ff == OP_AUTOSELECT)
						? '{is_read: 1'b1, addr: addr_ff, data: 16'h0000} // RULE_15 RULE_19
						: (op_ff == OP_PROGRAM) ? '{is_read: 1'b0,
							addr: addr_ff, data: data_ff}
						: wr(addr_ff, `DAT_ZERO); // RULE_02
				endcase
			end
			OP_BYPASS_PROG: begin
				n_cyc = 3'd2;
				cur = (idx_ff == 3'd0) ? wr(addr_ff, `DAT_PROGRAM)
					: '{is_read: 1'b0, addr: addr_ff, data: data_ff}; // RULE_07
			end
			OP_BYPASS_OUT: begin
				n_cyc = 3'd2;
				cur = (idx_ff == 3'd0) ? wr(bank(addr_ff, 22'h00_0000),
					`DAT_AUTOSEL) : wr(addr_ff, `DAT_ZERO); // RULE_08
			end
			OP_CHIP_ERASE, OP_SECT_ERASE: begin
				n_cyc = 3'd6;
				unique case (idx_ff)
					3'd0, 3'd3: cur = wr(u1, `DAT_UNLOCK1);
					3'd1, 3'd4: cur = wr(u2, `DAT_UNLOCK2);
					3'd2: cur = wr(u1, `DAT_ERASE); // RULE_09
					default: cur = (op_ff == OP_CHIP_ERASE)
						? wr(u1, `DAT_CHIP_ERASE)
						: wr({addr_ff[21:`ADR_SECTOR_LSB], 12'h000},
							`DAT_SECT_ERASE); // RULE_10 RULE_17
				endcase
			end
			OP_SUSPEND: cur = wr(bank(addr_ff, 22'h00_0000), `DAT_SUSPEND);
			OP_RESUME:  cur = wr(bank(addr_ff, 22'h00_0000), `DAT_RESUME);
			OP_QUERY: cur = wr(byte_ff ? `ADR_QUERY_B : `ADR_QUERY_W,
				`DAT_QUERY); // RULE_14
			default: cur = wr(addr_ff, `DAT_RESET);
		endcase
	end

	flash_bus_cycle u_cycle (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.start     (cyc_start),
		.is_read   (cur.is_read),
		.addr      (cur.addr),
		.wdata     (cur.data),
		.done      (cyc_done),
		.rdata     (cyc_rdata),
		.fl_addr   (fl_addr),
		.fl_dq_out (fl_dq_out),
		.fl_dq_oe  (fl_dq_oe),
		.fl_dq_in  (fl_dq_in),
		.fl_ce_n   (fl_ce_n),
		.fl_we_n   (fl_we_n),
		.fl_oe_n   (fl_oe_n)
	);

	logic run_ff;
	assign cyc_start = run_ff;

	// axi write path
	logic aw_ok;
	logic go_req;
	assign aw_ok = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = aw_ok;
	assign s_axi_wready  = aw_ok;
	assign go_req = aw_ok && s_axi_awaddr == `REG_CTRL
		&& s_axi_wstrb[0] && s_axi_wdata[`CTRL_GO_BIT] && !busy_ff;

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
			addr_ff      <= 22'h00_0000;
			data_ff      <= 16'h0000;
			op_ff        <= OP_READ;
			byte_ff      <= 1'b0;
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (aw_ok) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'b00;
				unique case (s_axi_awaddr)
					`REG_CTRL: if (!busy_ff) begin
						byte_ff <= s_axi_wdata[`CTRL_BYTE_BIT];
						op_ff   <= new_op;
					end else begin
						s_axi_bresp <= 2'b10;
					end
					`REG_ADDR: if (!busy_ff) addr_ff <= s_axi_wdata[21:0];
					`REG_DATA: if (!busy_ff) data_ff <= s_axi_wdata[15:0];
					default:   s_axi_bresp <= 2'b10;
				endcase
			end
		end
	end

	// sequence runner and mode tracking
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			busy_ff    <= 1'b0;
			run_ff     <= 1'b0;
			idx_ff     <= 3'd0;
			err_ff     <= 1'b0;
			rd_ff      <= 16'h0000;
			bypass_ff  <= 1'b0;
			region_ff  <= 1'b0;
			susp_ff    <= 1'b0;
			serase_ff  <= 1'b0;
			autosel_ff <= 1'b0;
		end else begin
			run_ff <= 1'b0;
			// erase over once the device reports ready again
			if (serase_ff && !susp_ff && ready_busy_n && !busy_ff)
				serase_ff <= 1'b0;
			if (go_req) begin
				busy_ff <= 1'b1;
				idx_ff  <= 3'd0;
				err_ff  <= !legal;
				run_ff  <= legal;
				if (!legal)
					busy_ff <= 1'b0;
			end else if (busy_ff && cyc_done) begin
				if (cur.is_read)
					rd_ff <= cyc_rdata;
				if (idx_ff + 3'd1 < n_cyc) begin
					idx_ff <= idx_ff + 3'd1;
					run_ff <= 1'b1;
				end else begin
					busy_ff <= 1'b0;
					unique case (op_ff)
						OP_BYPASS_IN:  bypass_ff <= 1'b1;
						OP_BYPASS_OUT: bypass_ff <= 1'b0;
						OP_REGION_IN:  region_ff <= 1'b1;
						OP_REGION_OUT: region_ff <= 1'b0;
						OP_SECT_ERASE: serase_ff <= 1'b1;
						OP_SUSPEND:    susp_ff   <= 1'b1;
						OP_RESUME:     susp_ff   <= 1'b0;
						OP_AUTOSELECT: autosel_ff <= 1'b1;
						OP_RESET:      autosel_ff <= 1'b0; // RULE_18
						default: ;
					endcase
				end
			end
		end
	end

	// axi read path
	logic [31:0] rd_mux;
	always_comb begin
		unique case (s_axi_araddr)
			`REG_CTRL:   rd_mux = {24'h00_0000, op_ff, 2'b00, byte_ff, 1'b0};
			`REG_ADDR:   rd_mux = {10'h000, addr_ff};
			`REG_DATA:   rd_mux = {16'h0000, rd_ff};
			`REG_STATUS: rd_mux = {24'h00_0000, autosel_ff, serase_ff,
				susp_ff, region_ff, bypass_ff, !ready_busy_n, err_ff,
				busy_ff}; // RULE_22
			default:     rd_mux = 32'h0000_0000;
		endcase
	end
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= (s_axi_araddr[1:0] != 2'b00
				|| s_axi_araddr > `REG_STATUS) ? 2'b10 : 2'b00;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : flash_seq_host

// ==== sim/flash_seq_host_chk.sv ====
`timescale 1ns/1ps
module flash_seq_host_chk (
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [21:0] fl_addr,
	input wire logic [15:0] fl_dq_out,
	input wire logic        fl_dq_oe,
	input wire logic        fl_ce_n,
	input wire logic        fl_we_n,
	input wire logic        fl_oe_n
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	sequence s_we2;
		!fl_we_n[*2] ##1 fl_we_n;
	endsequence
	sequence s_oe2;
		!fl_oe_n[*2] ##1 fl_oe_n;
	endsequence
	property p_we_len;
		$fell(fl_we_n) |-> s_we2;
	endproperty
	a_we_len: assert property (p_we_len)
		else $error("write strobe width wrong");
	property p_oe_len;
		$fell(fl_oe_n) |-> s_oe2;
	endproperty
	a_oe_len: assert property (p_oe_len)
		else $error("read strobe width wrong");
	property p_ce_cover;
		(!fl_we_n || !fl_oe_n) |-> !fl_ce_n;
	endproperty
	a_ce_cover: assert property (p_ce_cover)
		else $error("strobe outside chip select");
	property p_addr_hold;
		!fl_we_n |-> $stable(fl_addr) && $stable(fl_dq_out) && fl_dq_oe;
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("address or data moved in write pulse");
	property p_data_hold;
		$rose(fl_we_n) |-> $stable(fl_dq_out) && !fl_ce_n && fl_dq_oe;
	endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("data not held after write strobe");
	property p_rd_excl;
		!fl_oe_n |-> fl_we_n && !fl_dq_oe;
	endproperty
	a_rd_excl: assert property (p_rd_excl)
		else $error("host drives bus during read");
	property p_aw_rdy;
		s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	endproperty
	a_aw_rdy: assert property (p_aw_rdy)
		else $error("write accepted out of turn");
	property p_b_resp;
		s_axi_awvalid && s_axi_awready |=> s_axi_bvalid;
	endproperty
	a_b_resp: assert property (p_b_resp)
		else $error("write response late");
	property p_r_resp;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_resp: assert property (p_r_resp)
		else $error("read response late");
endmodule : flash_seq_host_chk
bind flash_seq_host flash_seq_host_chk chk (.*);

// ==== sim/flash_dev_model.sv ====
`timescale 1ns/1ps
module flash_dev_model (
	input  wire logic [21:0] fl_addr,
	input  wire logic [15:0] fl_dq_out,
	input  wire logic        fl_dq_oe,
	output logic      [15:0] fl_dq_in,
	input  wire logic        fl_ce_n,
	input  wire logic        fl_we_n,
	input  wire logic        fl_oe_n,
	output logic             ready_busy_n
);
	logic [37:0] log_q[$];
	logic [21:0] lat_a;
	logic [15:0] rd_v;
	logic [7:0]  prev;
	logic        prog;
	logic        ers;
	logic        sus;
	int          pleft;
	int          left;
	always @(negedge fl_we_n) if (!fl_ce_n) lat_a = fl_addr;
	always @(negedge fl_ce_n) if (!fl_we_n) lat_a = fl_addr;
	always @(posedge fl_we_n) if (!fl_ce_n) take(fl_dq_out);
	always @(posedge fl_ce_n) if (!fl_we_n) take(fl_dq_out);
	always_comb begin
		rd_v = 16'h5A3C;
		if (fl_addr[7:0] == 8'h03)
			rd_v = 16'h0080;
		if (fl_addr[7:0] == 8'h02)
			rd_v = 16'h0001;
	end
	// released bus shows the inverse, never a stale copy
	assign fl_dq_in = (!fl_oe_n && !fl_ce_n) ? rd_v : ~rd_v;
	task automatic take(input logic [15:0] d);
		log_q.push_back({lat_a, d});
		if (prog) begin
			prog = 1'b0;
			pleft = 10;
		end else if (ers && !sus) begin
			if (d[7:0] == 8'hB0)
				sus = 1'b1;
		end else if (sus && d[7:0] == 8'h30) begin
			sus = 1'b0;
		end else if (d[7:0] == 8'hA0) begin
			prog = 1'b1;
		end else if (d[7:0] == 8'h10 && prev == 8'h55) begin
			pleft = 20;
		end else if (d[7:0] == 8'h30 && prev == 8'h55) begin
			ers = 1'b1;
			left = 30;
		end
		prev = d[7:0];
	endtask : take
	initial begin
		ready_busy_n = 1'b1;
		prev = 8'h00;
		prog = 1'b0;
		ers = 1'b0;
		sus = 1'b0;
		pleft = 0;
		left = 0;
		#5;
		forever begin
			#100;
			if (pleft > 0)
				pleft = pleft - 1;
			if (ers && !sus)
				left = left - 1;
			if (left <= 0)
				ers = 1'b0;
			ready_busy_n = !(pleft > 0 || (ers && !sus));
		end
	end
endmodule : flash_dev_model

// ==== sim/flash_seq_host_bench.sv ====
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		check_count++; \
		if ((g) !== (e)) begin \
			n_errors++; \
			$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); \
		end \
	end
module flash_seq_host_bench;
	import flash_seq_pkg::*;
	logic        core_clk, reset_n, bm;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr, bq;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, ready_busy_n;
	logic [21:0] fl_addr;
	logic [15:0] fl_dq_out, fl_dq_in;
	logic        fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n;
	int          n_errors, check_count;
	localparam logic [21:0] ANY = 22'h3F_FFFF;
	flash_seq_host uut (.*);
	flash_dev_model dev (.*);
	always #20 core_clk = ~core_clk;
	task automatic report_and_stop();
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge core_clk);
		while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		bq = s_axi_bresp;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		rdat = s_axi_rdata;
		rr = s_axi_rresp;
	endtask : rd
	task automatic st(input int b, input logic v);
		rd(4'hC);
		`CHK(rdat[b], v)
	endtask : st
	task automatic idle();
		do rd(4'hC); while (rdat[2] !== 1'b0);
	endtask : idle
	task automatic go(input op_t op, input logic [21:0] a,
		input logic [15:0] d, input logic bad);
		wr(4'h4, {10'h0, a});
		wr(4'h8, {16'h0, d});
		wr(4'h0, {24'h0, op, 2'b00, bm, 1'b1});
		if (bad) begin
			st(1, 1'b1);
			`CHK(dev.log_q.size(), 0)
		end else begin
			wr(4'h0, 32'h0);
			`CHK(bq, 2'b10)
			do rd(4'hC); while (rdat[0] !== 1'b0);
		end
	endtask : go
	task automatic ex(input logic [21:0] a, input logic [15:0] d);
		logic [37:0] g;
		g = '1;
		if (dev.log_q.size() > 0)
			g = dev.log_q.pop_front();
		if (a === ANY)
			g[37:16] = ANY;
		if (d[15:8] === 8'h00)
			g[15:8] = 8'h00;
		`CHK(g, {a, d})
	endtask : ex
	task automatic u3(input logic [7:0] d);
		ex(bm ? 22'hAAA : 22'h555, 16'h00AA);
		ex(bm ? 22'h555 : 22'h2AA, 16'h0055);
		ex(bm ? 22'hAAA : 22'h555, {8'h00, d});
	endtask : u3
	task automatic e5();
		u3(8'h80);
		ex(22'h555, 16'h00AA);
		ex(22'h2AA, 16'h0055);
	endtask : e5
	initial begin
		#2_000_000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		core_clk = 1'b0;
		reset_n = 1'b0;
		bm = 1'b0;
		s_axi_awaddr = 4'h0;
		s_axi_araddr = 4'h0;
		s_axi_wstrb = 4'hF;
		s_axi_wdata = 32'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		n_errors = 0;
		check_count = 0;
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		rd(4'hC);
		`CHK(rdat, 32'h0000_0000)
		rd(4'h2);
		`CHK(rr, 2'b10)
		go(OP_READ, 22'h00_0040, 16'h0, 1'b0);
		`CHK(dev.log_q.size(), 0)
		rd(4'h8);
		`CHK(rdat, 32'h0000_5A3C)
		go(OP_REGION_IN, 22'h0, 16'h0, 1'b0);
		u3(8'h88);
		st(4, 1'b1);
		go(OP_REGION_OUT, 22'h0, 16'h0, 1'b0);
		u3(8'h90);
		ex(ANY, 16'h0000);
		st(4, 1'b0);
		go(OP_PROGRAM, 22'h12_3456, 16'hC35A, 1'b0);
		u3(8'hA0);
		ex(22'h12_3456, 16'hC35A);
		st(2, 1'b1);
		idle();
		go(OP_BYPASS_PROG, 22'h0, 16'h0, 1'b1);
		go(OP_BYPASS_IN, 22'h0, 16'h0, 1'b0);
		u3(8'h20);
		st(3, 1'b1);
		go(OP_BYPASS_PROG, 22'h0A_0010, 16'h9F61, 1'b0);
		ex(ANY, 16'h00A0);
		ex(22'h0A_0010, 16'h9F61);
		idle();
		go(OP_BYPASS_OUT, 22'h2A_0000, 16'h0, 1'b0);
		ex(22'h28_0000, 16'h0090);
		ex(ANY, 16'h0000);
		st(3, 1'b0);
		go(OP_SUSPEND, 22'h0, 16'h0, 1'b1);
		go(OP_CHIP_ERASE, 22'h0, 16'h0, 1'b0);
		e5();
		ex(22'h555, 16'h0010);
		idle();
		go(OP_SECT_ERASE, 22'h1F_3000, 16'h0, 1'b0);
		e5();
		ex(22'h1F_3000, 16'h0030);
		st(6, 1'b1);
		go(OP_PROGRAM, 22'h00_0100, 16'h0, 1'b1);
		go(OP_SUSPEND, 22'h1F_3000, 16'h0, 1'b0);
		ex(22'h18_0000, 16'h00B0);
		idle();
		st(5, 1'b1);
		go(OP_PROGRAM, 22'h00_0100, 16'h7E11, 1'b0);
		u3(8'hA0);
		ex(22'h00_0100, 16'h7E11);
		idle();
		go(OP_RESUME, 22'h1F_3000, 16'h0, 1'b0);
		ex(22'h18_0000, 16'h0030);
		st(5, 1'b0);
		go(OP_RESUME, 22'h1F_3000, 16'h0, 1'b1);
		do rd(4'hC); while (rdat[6] !== 1'b0);
		for (int i = 0; i < 2; i++) begin
			go(OP_AUTOSELECT, 22'(3 - i), 16'h0, 1'b0);
			u3(8'h90);
			`CHK(dev.log_q.size(), 0)
			st(7, 1'b1);
			rd(4'h8);
			`CHK(rdat[7:0], i ? 8'h01 : 8'h80)
			go(OP_RESET, 22'h0, 16'h0, 1'b0);
			ex(ANY, 16'h00F0);
			st(7, 1'b0);
		end
		go(OP_QUERY, 22'h0, 16'h0, 1'b0);
		ex(22'h55, 16'h0098);
		bm = 1'b1;
		go(OP_REGION_IN, 22'h0, 16'h0, 1'b0);
		u3(8'h88);
		report_and_stop();
	end
endmodule : flash_seq_host_bench
